//--- sbst_tap.v
// test access port controller for a synchronous sram
// assumes clk_sys much faster than tck; test pins asynchronous
`default_nettype none
`include "sbst_defs.vh"
module sbst_tap (
    input wire clk_sys,
    input wire rstn,
    input wire tck,
    input wire tms,
    input wire tms_oe,
    input wire tdi,
    input wire tdi_oe,
    input wire [`SBST_BSR_W-1:0] ring,
    output reg tdo,
    output reg tdo_oe,
    output reg mem_hiz
);
    localparam [15:0] ST_RESET = 16'h0001;
    localparam [15:0] ST_IDLE = 16'h0002;
    localparam [15:0] ST_SEL_DR = 16'h0004;
    localparam [15:0] ST_CAP_DR = 16'h0008;
    localparam [15:0] ST_SH_DR = 16'h0010;
    localparam [15:0] ST_EX1_DR = 16'h0020;
    localparam [15:0] ST_PA_DR = 16'h0040;
    localparam [15:0] ST_EX2_DR = 16'h0080;
    localparam [15:0] ST_UP_DR = 16'h0100;
    localparam [15:0] ST_SEL_IR = 16'h0200;
    localparam [15:0] ST_CAP_IR = 16'h0400;
    localparam [15:0] ST_SH_IR = 16'h0800;
    localparam [15:0] ST_EX1_IR = 16'h1000;
    localparam [15:0] ST_PA_IR = 16'h2000;
    localparam [15:0] ST_EX2_IR = 16'h4000;
    localparam [15:0] ST_UP_IR = 16'h8000;

    // undriven pins read high, modelling the internal pull-ups
    wire tms_pin = tms_oe ? tms : 1'b1;
    wire tdi_pin = tdi_oe ? tdi : 1'b1;
    wire [3:0] synced;
    sbst_sync u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d_in({tms_pin, tdi_pin, tck, 1'b0}),
        .rst_val(`SBST_SYNC_RST),
        .q_out(synced)
    );
    wire tms_s = synced[3];
    wire tdi_s = synced[2];
    wire tck_s = synced[1];

    reg tck_d;
    reg [15:0] state;
    reg [15:0] next_state;
    reg [`SBST_CNT_W-1:0] tms_cnt;
    reg [`SBST_IR_W-1:0] ir_sh;
    reg [`SBST_IR_W-1:0] ir;
    reg byp;
    reg [`SBST_ID_W-1:0] id_sh;
    reg so_sel;
    // tck stays low when unused, so no edges ever reach the logic
    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;
    wire bsr_so;

    // only the boundary register, id and bypass exist as data paths
    wire sel_bsr = (ir == `SBST_INS_EXTEST) | (ir == `SBST_INS_SAMPZ) |
                   (ir == `SBST_INS_SAMPLE);
    wire sel_id = (ir == `SBST_INS_IDCODE);
    // reserved and bypass codes fall through to bypass
    wire sel_byp = ~sel_bsr & ~sel_id;

    always @* begin
        case (state)
            ST_RESET: begin
                if (tms_s) begin
                    next_state = ST_RESET;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (tms_s) begin
                    next_state = ST_SEL_DR;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_SEL_DR: begin
                if (tms_s) begin
                    next_state = ST_SEL_IR;
                end else begin
                    next_state = ST_CAP_DR;
                end
            end
            ST_CAP_DR: begin
                if (tms_s) begin
                    next_state = ST_EX1_DR;
                end else begin
                    next_state = ST_SH_DR;
                end
            end
            ST_SH_DR: begin
                if (tms_s) begin
                    next_state = ST_EX1_DR;
                end else begin
                    next_state = ST_SH_DR;
                end
            end
            ST_EX1_DR: begin
                if (tms_s) begin
                    next_state = ST_UP_DR;
                end else begin
                    next_state = ST_PA_DR;
                end
            end
            ST_PA_DR: begin
                if (tms_s) begin
                    next_state = ST_EX2_DR;
                end else begin
                    next_state = ST_PA_DR;
                end
            end
            ST_EX2_DR: begin
                if (tms_s) begin
                    next_state = ST_UP_DR;
                end else begin
                    next_state = ST_SH_DR;
                end
            end
            ST_UP_DR: begin
                if (tms_s) begin
                    next_state = ST_SEL_DR;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_SEL_IR: begin
                if (tms_s) begin
                    next_state = ST_RESET;
                end else begin
                    next_state = ST_CAP_IR;
                end
            end
            ST_CAP_IR: begin
                if (tms_s) begin
                    next_state = ST_EX1_IR;
                end else begin
                    next_state = ST_SH_IR;
                end
            end
            ST_SH_IR: begin
                if (tms_s) begin
                    next_state = ST_EX1_IR;
                end else begin
                    next_state = ST_SH_IR;
                end
            end
            ST_EX1_IR: begin
                if (tms_s) begin
                    next_state = ST_UP_IR;
                end else begin
                    next_state = ST_PA_IR;
                end
            end
            ST_PA_IR: begin
                if (tms_s) begin
                    next_state = ST_EX2_IR;
                end else begin
                    next_state = ST_PA_IR;
                end
            end
            ST_EX2_IR: begin
                if (tms_s) begin
                    next_state = ST_UP_IR;
                end else begin
                    next_state = ST_SH_IR;
                end
            end
            ST_UP_IR: begin
                if (tms_s) begin
                    next_state = ST_SEL_DR;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_RESET;
        endcase
    end

    // forced reset on the fifth high, whatever the fsm says
    wire tms_fifth = tms_s & (tms_cnt == `SBST_RST_TMS_CNT - 3'h1);
    reg [15:0] next_tap;

    always @* begin
        if (tms_fifth) begin
            next_tap = ST_RESET;
        end else begin
            next_tap = next_state;
        end
    end

    // edge detector resets to the idle low level of the test clock
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end

    // rstn models power-up; it also clears mem_hiz, the memory-side output
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= next_tap;
        end
    end

    // redundant watchdog; the fsm already reaches reset in five
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tms_cnt <= {`SBST_CNT_W{1'b0}};
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_cnt <= {`SBST_CNT_W{1'b0}};
            end else if (tms_cnt != `SBST_RST_TMS_CNT) begin
                tms_cnt <= tms_cnt + 3'h1;
            end
        end
    end

    // loaded on entry, so memory high-z follows at the very next fall
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ir <= `SBST_INS_IDCODE;
        end else if (tck_rise) begin
            if (next_tap == ST_RESET) begin
                ir <= `SBST_INS_IDCODE;
            end else if (next_tap == ST_UP_IR) begin
                ir <= ir_sh;
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ir_sh <= `SBST_IR_CAPTURE;
        end else if (tck_rise) begin
            if (state == ST_CAP_IR) begin
                ir_sh <= `SBST_IR_CAPTURE;
            end else if (state == ST_SH_IR) begin
                ir_sh <= {tdi_s, ir_sh[`SBST_IR_W-1:1]};
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            id_sh <= {`SBST_ID_W{1'b0}};
        end else if (tck_rise && sel_id) begin
            if (state == ST_CAP_DR) begin
                id_sh <= `SBST_ID_VALUE;
            end else if (state == ST_SH_DR) begin
                id_sh <= {tdi_s, id_sh[`SBST_ID_W-1:1]};
            end
        end
    end

    // capture clears the bit, so a bypassed part always shifts out a zero first
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            byp <= 1'b0;
        end else if (tck_rise && sel_byp) begin
            if (state == ST_CAP_DR) begin
                byp <= 1'b0;
            end else if (state == ST_SH_DR) begin
                byp <= tdi_s;
            end
        end
    end

    sbst_bsr u_bsr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .capture(tck_rise & (state == ST_CAP_DR) & sel_bsr),
        .shift(tck_rise & (state == ST_SH_DR) & sel_bsr),
        .tdi(tdi_s),
        .ring(ring),
        .so(bsr_so)
    );

    always @* begin
        if (state == ST_SH_IR) begin
            so_sel = ir_sh[0];
        end else if (sel_id) begin
            so_sel = id_sh[0];
        end else if (sel_bsr) begin
            so_sel = bsr_so;
        end else begin
            so_sel = byp;
        end
    end

    // outputs move only on tck falls, meeting standard devices' timing
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
            mem_hiz <= 1'b0;
        end else if (tck_fall) begin
            tdo <= so_sel;
            tdo_oe <= (state == ST_SH_DR) | (state == ST_SH_IR);
            // test reset loads idcode, which releases memory outputs from high-z
            mem_hiz <= (ir == `SBST_INS_EXTEST) | (ir == `SBST_INS_SAMPZ);
        end
    end
endmodule // sbst_tap
`default_nettype wire

//--- sbst_defs.vh
// constants for the sram boundary-scan test port
// assumes inclusion by the tap and boundary-register design files of the port
`ifndef SBST_DEFS_VH
`define SBST_DEFS_VH

`define SBST_IR_W 3
`define SBST_ID_W 32
`define SBST_BSR_W 8
`define SBST_SYNC_W 2
`define SBST_RST_TMS_CNT 3'h5
`define SBST_CNT_W 3
// synchroniser reset: mode select and data-in idle high, test clock idles low
`define SBST_SYNC_RST 4'hc

// instruction codes
`define SBST_INS_EXTEST 3'h0
`define SBST_INS_IDCODE 3'h1
`define SBST_INS_SAMPZ 3'h2
`define SBST_INS_RSVD3 3'h3
`define SBST_INS_SAMPLE 3'h4
`define SBST_INS_RSVD5 3'h5
`define SBST_INS_RSVD6 3'h6
`define SBST_INS_BYPASS 3'h7

`define SBST_IR_CAPTURE 3'h1
// value arbitrary, stands in for a maker's code
`define SBST_ID_VALUE 32'h1234_5679

`endif

//--- sbst_sync.v
// two-flop synchroniser for the test pins
// assumes inputs asynchronous to clk_sys
`default_nettype none
module sbst_sync (
    input wire clk_sys,
    input wire rstn,
    input wire [3:0] d_in,
    input wire [3:0] rst_val,
    output wire [3:0] q_out
);
    reg [3:0] stage1;
    reg [3:0] stage2;
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_bit
            // reset value constant per instance, chosen by caller tie-offs
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= d_in[i] ^ rst_val[i];
                    stage2[i] <= stage1[i];
                end
            end
            assign q_out[i] = stage2[i] ^ rst_val[i];
        end
    endgenerate
endmodule // sbst_sync
`default_nettype wire

//--- sbst_bsr.v
// boundary-scan shift and capture register
// assumes capture and shift strobes from the tap controller
`default_nettype none
`include "sbst_defs.vh"
module sbst_bsr (
    input wire clk_sys,
    input wire rstn,
    input wire capture,
    input wire shift,
    input wire tdi,
    input wire [`SBST_BSR_W-1:0] ring,
    output wire so
);
    reg [`SBST_BSR_W-1:0] chain;
    // msb toward data-in, lsb toward data-out
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chain <= {`SBST_BSR_W{1'b0}};
        end else if (capture) begin
            chain <= ring;
        end else if (shift) begin
            chain <= {tdi, chain[`SBST_BSR_W-1:1]};
        end
    end
    assign so = chain[0];
endmodule // sbst_bsr
`default_nettype wire

//--- sbst_tap_sva.sv
// assertions on the test port pins
// assumes tck far slower than clk_sys
`default_nettype none
module sbst_tap_sva (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_oe,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic mem_hiz
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] tk;
    logic last_tms;
    logic [2:0] hi_cnt;
    // released pin reads high through the pull-up
    wire tms_v = tms_oe ? tms : 1'b1;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tk <= 2'b00;
            last_tms <= 1'b1;
            hi_cnt <= 3'h0;
        end else begin
            tk <= {tk[0], tck};
            if (tk == 2'b01) begin
                last_tms <= tms_v;
                hi_cnt <= !tms_v ? 3'h0 : (hi_cnt == 3'h5) ? 3'h5 : hi_cnt + 3'h1;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    out_on_fall_a: assert property ($changed({tdo, tdo_oe, mem_hiz}) |-> tk == 2'b00)
        else $error("output moved while tck high");
    power_quiet_a: assert property ($rose(rstn) |-> !tdo_oe && !mem_hiz)
        else $error("pins active after power-up");
    tms_reset_a: assert property (hi_cnt == 3'h5 |-> ##[0:16] !tdo_oe && !mem_hiz)
        else $error("no reset after five tms highs");
    oe_enter_a: assert property ($rose(tdo_oe) |-> !last_tms)
        else $error("drive began without tms low");
    oe_leave_a: assert property ($fell(tdo_oe) |-> last_tms)
        else $error("drive ended without tms high");
    hiz_update_a: assert property ($changed(mem_hiz) |-> last_tms && !tdo_oe)
        else $error("high-z moved outside update");
    oe_hold_a: assert property ($changed(tdo_oe) |=> $stable(tdo_oe) [*8])
        else $error("drive flag glitched");
    tms_high_a: assert property (hi_cnt >= 3'h2 && tk == 2'b11 |-> !tdo_oe)
        else $error("drive in a non-shift state");
    cover property (hi_cnt == 3'h5);
    cover property ($rose(tdo_oe));
    cover property ($rose(mem_hiz));
endmodule // sbst_tap_sva
`default_nettype wire

//--- sbst_scan_host.sv
// external scan controller driving the test pins
// assumes its tasks are called one at a time
`default_nettype none
module sbst_scan_host (
    output var logic tck,
    output var logic tms,
    output var logic tms_oe,
    output var logic tdi,
    output var logic tdi_oe,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 10ps;
    initial begin
        tck = 1'b0;
        {tms, tms_oe, tdi, tdi_oe} = 4'h0;
    end
    // pins change mid-low, far from the rising edge
    task automatic step(input logic m, input logic d, input logic en, output logic o);
        tms <= m;
        tdi <= d;
        tms_oe <= en;
        tdi_oe <= en;
        #31.25 tck <= 1'b1;
        o = tdo;
        #62.5 tck <= 1'b0;
        #31.25;
    endtask
    // from idle to shift, n bits lsb first, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        step(1'b1, 1'b0, 1'b1, o);
        if (ir) step(1'b1, 1'b0, 1'b1, o);
        step(1'b0, 1'b0, 1'b1, o);
        step(1'b0, 1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1, o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, 1'b1, o);
        step(1'b0, 1'b0, 1'b1, o);
    endtask
endmodule // sbst_scan_host
`default_nettype wire

//--- test_sram_boundary_scan_tap.sv
// self-checking bench for the sram boundary-scan test port
// assumes the scan host model drives the test pins
`default_nettype none
`include "sbst_defs.vh"
module test_sram_boundary_scan_tap;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ID = `SBST_ID_VALUE;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [`SBST_BSR_W-1:0] ring = 8'ha5;
    wire tck, tms, tms_oe, tdi, tdi_oe, tdo, tdo_oe, mem_hiz;
    // an undriven data-out shows the inverse, so reads outside shift states fail
    wire tdo_bus = tdo_oe ? tdo : ~tdo;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 clk_sys = ~clk_sys;
    sbst_tap i_dut (.clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tms(tms), .tms_oe(tms_oe),
        .tdi(tdi), .tdi_oe(tdi_oe), .ring(ring), .tdo(tdo), .tdo_oe(tdo_oe), .mem_hiz(mem_hiz));
    sbst_scan_host i_host (.tck(tck), .tms(tms), .tms_oe(tms_oe), .tdi(tdi), .tdi_oe(tdi_oe),
        .tdo(tdo_bus));
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic t_idcode();
        logic [31:0] q;
        i_host.scan(1'b0, 32, 32'h0, q);
        chk("id", ID, q);
    endtask
    // every code: ir capture, high-z, then which register sits in the path
    task automatic t_codes();
        logic [31:0] q;
        logic [8:0] e;
        for (int c = 0; c < 8; c++) begin
            i_host.scan(1'b1, 3, 32'(c), q);
            chk("ir capture", `SBST_IR_CAPTURE, 32'(q[2:0]));
            chk("hiz", 32'(c == 0 || c == 2), 32'(mem_hiz));
            @(posedge clk_sys);
            ring <= ~ring;
            i_host.scan(1'b0, 9, 32'h133, q);
            e = c == 1 ? ID[8:0] : (c == 0 || c == 2 || c == 4) ? {1'b1, ring} : 9'h066;
            chk("dr path", 32'(e), 32'(q[8:0]));
        end
    endtask
    // from shift-dr under extest, tms left floating must read high and reset the port
    task automatic t_tms_reset();
        logic [31:0] q;
        logic o;
        i_host.scan(1'b1, 3, 32'h0, q);
        chk("hiz extest", 32'h1, 32'(mem_hiz));
        i_host.step(1'b1, 1'b0, 1'b1, o);
        repeat (2) i_host.step(1'b0, 1'b0, 1'b1, o);
        repeat (5) i_host.step(1'b0, 1'b0, 1'b0, o);
        chk("hiz after reset", 32'h0, 32'(mem_hiz));
        i_host.step(1'b0, 1'b0, 1'b1, o);
        i_host.scan(1'b0, 32, 32'hffff_ffff, q);
        chk("id after reset", ID, q);
    endtask
    initial begin
        logic o;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("idle pins", 32'h0, 32'({tdo_oe, mem_hiz}));
        i_host.step(1'b0, 1'b0, 1'b1, o);
        t_idcode();
        t_codes();
        t_tms_reset();
        complete_run();
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end
endmodule // test_sram_boundary_scan_tap
bind sbst_tap sbst_tap_sva i_sva (.clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tms(tms),
    .tms_oe(tms_oe), .tdo(tdo), .tdo_oe(tdo_oe), .mem_hiz(mem_hiz));
`default_nettype wire
